// ### pcie_subsys_pkg.sv
/*
 * package for the pcie host subsystem: apb register map, field positions,
 * reset values, interrupt line numbers and the msi rewrite constants.
 * assumes a 32-bit apb master and a single 250 mhz clock.
 */
`default_nettype none
package pcie_subsys_pkg;
	// ==================== bus widths ====================
	localparam int ADDR_W = 32;               // system bus address width
	localparam int DATA_W = 32;               // system bus data width
	localparam int IRQ_LINES = 224;           // interrupt output array width
	localparam int ENDPOINTS = 2;             // endpoint instances 0 and 1
	// ==================== register offsets ====================
	localparam logic [11:0] OFF_EP0_CFG    = 12'h000; // endpoint 0 configuration
	localparam logic [11:0] OFF_EP1_CFG    = 12'h004; // endpoint 1 configuration
	localparam logic [11:0] OFF_TS_BASE_LO = 12'h008; // translation service base, low word
	localparam logic [11:0] OFF_TS_BASE_HI = 12'h00C; // translation service base, high word
	localparam logic [11:0] OFF_XLAT_ID    = 12'h010; // translator msi source id
	localparam logic [11:0] OFF_INTX       = 12'h014; // legacy lines raised per endpoint
	localparam logic [11:0] OFF_STATUS     = 12'h018; // line and event status, read only
	localparam logic [11:0] OFF_EVENT      = 12'h01C; // write pulses the peer event
	localparam logic [11:0] OFF_EP0_CAP    = 12'h020; // endpoint 0 advertised capability view
	localparam logic [11:0] OFF_EP1_CAP    = 12'h024; // endpoint 1 advertised capability view
	// ==================== endpoint config fields ====================
	localparam int F_BUS_LSB    = 0;   // bus number, 8 bits
	localparam int F_DEV_LSB    = 8;   // device number, 5 bits
	localparam int F_WIDE0      = 16;  // bar index 0 wide select
	localparam int F_WIDE2      = 17;  // bar index 2 wide select
	localparam int F_WIDE4      = 18;  // bar index 4 wide select
	localparam int F_MSIX       = 19;  // msi-x support enable
	localparam int F_SIZE0      = 20;  // bar index 0 region size nonzero
	localparam int F_SIZE2      = 21;  // bar index 2 region size nonzero
	localparam int F_SIZE4      = 22;  // bar index 4 region size nonzero
	localparam logic [31:0] EP_CFG_RST = 32'h0070_0000; // bus 0, dev 0, 32-bit bars, no msi-x
	localparam logic [31:0] EP_CFG_MASK = 32'h007F_1FFF; // implemented bits
	// ==================== reset values ====================
	localparam logic [63:0] TS_BASE_RST = 64'h0000_0000_2F02_0000; // msi target base
	localparam logic [31:0] XLAT_ID_RST = 32'h0001_0000;           // translator device id
	localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;          // read data of unmapped
	// ==================== interrupt numbering ====================
	localparam int IRQ_INTA = 200;         // first swizzled line id
	localparam int IRQ_SERR = 207;         // system error line id
	localparam logic [7:0] INT_PIN_INTA = 8'h01; // interrupt pin field value
	localparam logic [1:0] PIN_IDX_INTA = 2'h0;  // endpoint pin index of inta
	// ==================== window decode ====================
	localparam logic [ADDR_W-1:0] CLAIM_BASE = 32'h0000_0000; // local register window base
	localparam logic [ADDR_W-1:0] CLAIM_MASK = 32'hFFFF_F000; // 4 kbyte window
	typedef enum logic [1:0] {FWD_IDLE = 2'b00, FWD_REQ = 2'b01, FWD_DONE = 2'b11} fwd_state_t;
	typedef enum logic [1:0] {MSI_IDLE = 2'b00, MSI_REQ = 2'b01, MSI_DONE = 2'b11} msi_state_t;
endpackage
`default_nettype wire

// ### ep_cfg_if.sv
/*
 * endpoint configuration carrier between the top and each endpoint wrapper.
 * assumes the top owns the configuration word and the wrapper only decodes it.
 */
`timescale 1ns/1ns
`default_nettype none
interface ep_cfg_if;
	logic [31:0] cfg;        // raw configuration word
	logic [7:0]  bus_num;    // decoded bus number
	logic [4:0]  dev_num;    // decoded device number
	logic [7:0]  int_pin;    // interrupt pin field
	logic [2:0]  bar_wide;   // effective 64-bit select, bars 0/2/4
	logic        msix_cap;   // msi-x capability listed
	logic [1:0]  line_idx;   // swizzled bridge line
	modport top (output cfg, input bus_num, dev_num, int_pin, bar_wide, msix_cap, line_idx);
	modport ep  (input cfg, output bus_num, dev_num, int_pin, bar_wide, msix_cap, line_idx);
endinterface
`default_nettype wire

// ### pcie_endpoint_cfg.sv
/*
 * one endpoint wrapper: decodes bus/device numbers, bar widths, msi-x
 * capability and the swizzled legacy line. assumes pclk/presetn of the top.
 */
`timescale 1ns/1ns
`default_nettype none
module pcie_endpoint_cfg
	import pcie_subsys_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	ep_cfg_if.ep      cfg_if
);
	// ==================== swizzle ====================
	// bridge line = (device + pin index) mod 4
	function automatic logic [1:0] swizzle(input logic [4:0] dev, input logic [1:0] pin);
		logic [4:0] sum;
		sum = dev + {3'b000, pin};
		return sum[1:0];
	endfunction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_if.bus_num  <= 8'h00;
			cfg_if.dev_num  <= 5'h00;
			cfg_if.int_pin  <= INT_PIN_INTA;
			cfg_if.bar_wide <= 3'b000;
			cfg_if.msix_cap <= 1'b0;
			cfg_if.line_idx <= PIN_IDX_INTA;
		end else begin
			cfg_if.bus_num  <= cfg_if.cfg[F_BUS_LSB +: 8];
			cfg_if.dev_num  <= cfg_if.cfg[F_DEV_LSB +: 5];
			cfg_if.int_pin  <= INT_PIN_INTA;
			// three bars, 32 or 64 wide
			cfg_if.bar_wide <= {cfg_if.cfg[F_WIDE4] & cfg_if.cfg[F_SIZE4],
			                    cfg_if.cfg[F_WIDE2] & cfg_if.cfg[F_SIZE2],
			                    cfg_if.cfg[F_WIDE0] & cfg_if.cfg[F_SIZE0]};
			cfg_if.msix_cap <= cfg_if.cfg[F_MSIX];
			cfg_if.line_idx <= swizzle(cfg_if.cfg[F_DEV_LSB +: 5], PIN_IDX_INTA);
		end
	end
	// ==================== checks ====================
	a_msix_follows: assert property (@(posedge pclk) disable iff (!presetn)
		##1 cfg_if.msix_cap == $past(cfg_if.cfg[F_MSIX])) else $error("msix cap mismatch");
	a_pin_is_inta: assert property (@(posedge pclk) disable iff (!presetn)
		cfg_if.int_pin == INT_PIN_INTA) else $error("int pin not inta");
	a_swizzle_map: assert property (@(posedge pclk) disable iff (!presetn)
		##1 cfg_if.line_idx == $past(cfg_if.cfg[F_DEV_LSB +: 2])) else $error("bad swizzle");
	a_bar_narrow: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(cfg_if.cfg[F_SIZE0]) |-> !cfg_if.bar_wide[0]) else $error("wide bar w/o size");
endmodule
`default_nettype wire

// ### pcie_host_subsystem.sv
/*
 * pcie host subsystem top: apb slave for its own registers, forwarding of
 * unclaimed transfers, dma master, msi payload rewrite, legacy interrupt
 * routing and the peer event. assumes one clock pclk and reset presetn.
 */
// Register access over APB and the register addresses were decided locally.
// Function
// - endpoints report inta pin value one
// - swizzle line is device plus pin mod4
// - msi-x capability only when enabled
// - msi-x defaults disabled, enabled per device
// - msi to controller carries source device id
// - three bars, each 32 or 64 bits
// - bars 0,2,4 wide only if sized
// - bus number configurable, decodes config access
// - device number configurable 0 to 31
// - exactly two endpoint instances
// - unclaimed transfers forwarded unchanged downstream
// - dma on its own master port
// - interrupt array of 224 lines
// - reset returns all state to defaults
// - event signalled on peer event output
// - translator msi uses configurable id
// - msi target base configurable, 64 bits
`timescale 1ns/1ns
`default_nettype none
module pcie_host_subsystem
	import pcie_subsys_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave from the system
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [DATA_W-1:0]    pwdata,
	output logic      [DATA_W-1:0]    prdata,
	output logic                      pready,
	output logic                      pslverr,
	// apb master forwarding unclaimed transfers
	output logic                      fwd_psel,
	output logic                      fwd_penable,
	output logic                      fwd_pwrite,
	output logic      [ADDR_W-1:0]    fwd_paddr,
	output logic      [DATA_W-1:0]    fwd_pwdata,
	input  wire logic [DATA_W-1:0]    fwd_prdata,
	input  wire logic                 fwd_pready,
	input  wire logic                 fwd_pslverr,
	// endpoint msi write requests (address, data) and bus-number decode check
	input  wire logic [1:0]           ep_msi_req,
	input  wire logic [63:0]          ep_msi_addr,
	input  wire logic [31:0]          ep_msi_data,
	input  wire logic                 xlat_msi_req,
	input  wire logic                 serr_in,
	input  wire logic [7:0]           cfg_bus_in,
	output logic      [1:0]           cfg_hit,
	// dma master (apb style)
	output logic                      dma_psel,
	output logic                      dma_penable,
	output logic                      dma_pwrite,
	output logic      [63:0]          dma_paddr,
	output logic      [DATA_W-1:0]    dma_pwdata,
	input  wire logic                 dma_pready,
	output logic                      msi_busy,
	// interrupt array and peer event
	output logic      [IRQ_LINES-1:0] interrupts,
	output logic                      sev_out
);
	// ==================== state ====================
	logic [31:0]    ep_cfg [ENDPOINTS];    // endpoint configuration words
	logic [63:0]    ts_base;               // translation_service_base
	logic [31:0]    xlat_id;               // translator_msi_source_id
	logic [1:0]     intx_raise;            // legacy line request per endpoint
	logic           event_pend;            // peer event pulse request
	fwd_state_t     fwd_state;             // forwarding sequencer
	msi_state_t     msi_state;             // msi/dma sequencer
	logic           claim;                 // address hits local window
	logic           setup;                 // apb setup phase
	logic [DATA_W-1:0] next_rdata;         // local read mux
	logic           next_err;              // unmapped local access
	ep_cfg_if       cfg_bus [ENDPOINTS](); // endpoint carriers

	// ==================== endpoints ====================
	// two endpoint instances
	for (genvar i = 0; i < ENDPOINTS; i++) begin : g_ep
		assign cfg_bus[i].cfg = ep_cfg[i];
		pcie_endpoint_cfg u_ep (
			.pclk    (pclk),
			.presetn (presetn),
			.cfg_if  (cfg_bus[i].ep)
		);
	end

	assign setup = psel && !penable;
	assign claim = (paddr & CLAIM_MASK) == CLAIM_BASE;

	// ==================== local read mux ====================
	function automatic logic [31:0] cap_view(input logic [2:0] w, input logic m, input logic [7:0] p,
	                                         input logic [1:0] l);
		return {16'h0000, p, 1'b0, l, m, 1'b0, w};
	endfunction
	// device id is the requester id: bus, device, function 0
	function automatic logic [31:0] devid(input logic [7:0] b, input logic [4:0] d);
		return {16'h0000, b, d, 3'b000};
	endfunction
	always_comb begin
		next_rdata = BUS_ERR_DATA;
		next_err   = 1'b0;
		case (paddr[11:0])
			OFF_EP0_CFG:    next_rdata = ep_cfg[0];
			OFF_EP1_CFG:    next_rdata = ep_cfg[1];
			OFF_TS_BASE_LO: next_rdata = ts_base[31:0];
			OFF_TS_BASE_HI: next_rdata = ts_base[63:32];
			OFF_XLAT_ID:    next_rdata = xlat_id;
			OFF_INTX:       next_rdata = {30'h0, intx_raise};
			OFF_STATUS:     next_rdata = {27'h0, event_pend, msi_busy, interrupts[IRQ_SERR],
			                              cfg_hit};
			OFF_EVENT:      next_rdata = BUS_ERR_DATA;
			OFF_EP0_CAP:    next_rdata = cap_view(cfg_bus[0].bar_wide, cfg_bus[0].msix_cap,
			                                      cfg_bus[0].int_pin, cfg_bus[0].line_idx);
			OFF_EP1_CAP:    next_rdata = cap_view(cfg_bus[1].bar_wide, cfg_bus[1].msix_cap,
			                                      cfg_bus[1].int_pin, cfg_bus[1].line_idx);
			default:        next_err   = 1'b1;
		endcase
	end

	// ==================== apb slave answer ====================
	// local access answers one cycle after setup; forwarded ones one cycle after downstream answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			if (setup && claim) begin
				pready  <= 1'b1;
				prdata  <= pwrite ? BUS_ERR_DATA : next_rdata;
				pslverr <= next_err;
			end else if (fwd_state == FWD_REQ && fwd_penable && fwd_pready) begin
				pready  <= 1'b1;
				prdata  <= fwd_prdata;
				pslverr <= fwd_pslverr;
			end
		end
	end

	// ==================== register writes ====================
	// all fields back to defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_cfg[0] <= EP_CFG_RST;
			ep_cfg[1] <= EP_CFG_RST;
			ts_base   <= TS_BASE_RST;
			xlat_id   <= XLAT_ID_RST;
			intx_raise <= 2'b00;
		end else if (setup && claim && pwrite) begin
			case (paddr[11:0])
				// bus and device numbers set here
				OFF_EP0_CFG:    ep_cfg[0] <= pwdata & EP_CFG_MASK;
				OFF_EP1_CFG:    ep_cfg[1] <= pwdata & EP_CFG_MASK;
				OFF_TS_BASE_LO: ts_base[31:0]  <= pwdata;
				OFF_TS_BASE_HI: ts_base[63:32] <= pwdata;
				OFF_XLAT_ID:    xlat_id <= pwdata;
				OFF_INTX:       intx_raise <= pwdata[1:0];
				default:        ;
			endcase
		end
	end

	// ==================== peer event ====================
	// one-cycle event pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_pend <= 1'b0;
			sev_out    <= 1'b0;
		end else begin
			sev_out    <= event_pend;
			event_pend <= setup && claim && pwrite && paddr[11:0] == OFF_EVENT;
		end
	end

	// ==================== forwarding master ====================
	// pass unclaimed transfer unchanged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_state   <= FWD_IDLE;
			fwd_psel    <= 1'b0;
			fwd_penable <= 1'b0;
			fwd_pwrite  <= 1'b0;
			fwd_paddr   <= 32'h0000_0000;
			fwd_pwdata  <= 32'h0000_0000;
		end else begin
			case (fwd_state)
				FWD_IDLE: if (setup && !claim) begin
					fwd_state  <= FWD_REQ;
					fwd_psel   <= 1'b1;
					fwd_pwrite <= pwrite;
					fwd_paddr  <= paddr;
					fwd_pwdata <= pwdata;
				end
				FWD_REQ: begin
					if (fwd_penable && fwd_pready) begin
						fwd_state   <= FWD_DONE;
						fwd_psel    <= 1'b0;
						fwd_penable <= 1'b0;
					end else begin
						fwd_penable <= 1'b1;
					end
				end
				// waits out the upstream access phase end
				FWD_DONE: fwd_state <= FWD_IDLE;
				default:  fwd_state <= FWD_IDLE;
			endcase
		end
	end

	// ==================== config decode ====================
	// bus number selects endpoint
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_hit <= 2'b00;
		end else begin
			cfg_hit <= {cfg_bus_in == cfg_bus[1].bus_num, cfg_bus_in == cfg_bus[0].bus_num};
		end
	end

	// ==================== msi rewrite / dma master ====================
	// endpoint traffic on dma port only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msi_state   <= MSI_IDLE;
			dma_psel    <= 1'b0;
			dma_penable <= 1'b0;
			dma_pwrite  <= 1'b0;
			dma_paddr   <= 64'h0;
			dma_pwdata  <= 32'h0000_0000;
			msi_busy    <= 1'b0;
		end else begin
			case (msi_state)
				MSI_IDLE: if (|ep_msi_req || xlat_msi_req) begin
					msi_state  <= MSI_REQ;
					msi_busy   <= 1'b1;
					dma_psel   <= 1'b1;
					dma_pwrite <= 1'b1;
					if (xlat_msi_req) begin
						dma_paddr  <= ts_base;
						dma_pwdata <= xlat_id;
					end else begin
						dma_paddr  <= ep_msi_addr;
						if (ep_msi_addr == ts_base) begin
							dma_pwdata <= ep_msi_req[0] ? devid(cfg_bus[0].bus_num, cfg_bus[0].dev_num)
							                            : devid(cfg_bus[1].bus_num, cfg_bus[1].dev_num);
						end else begin
							dma_pwdata <= ep_msi_data;
						end
					end
				end
				MSI_REQ: begin
					if (dma_penable && dma_pready) begin
						msi_state   <= MSI_DONE;
						dma_psel    <= 1'b0;
						dma_penable <= 1'b0;
					end else begin
						dma_penable <= 1'b1;
					end
				end
				MSI_DONE: begin
					msi_state <= MSI_IDLE;
					msi_busy  <= 1'b0;
				end
				default: msi_state <= MSI_IDLE;
			endcase
		end
	end

	// ==================== interrupt array ====================
	// registered 224-line array
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupts <= '0;
		end else begin
			interrupts <= '0;
			// swizzled line onto ids 200..203
			// unrolled: an interface array takes constant indices only
			if (intx_raise[0])
				interrupts[IRQ_INTA + int'(cfg_bus[0].line_idx)] <= 1'b1;
			if (intx_raise[1])
				interrupts[IRQ_INTA + int'(cfg_bus[1].line_idx)] <= 1'b1;
			interrupts[IRQ_SERR] <= serr_in;
		end
	end

	// ==================== checks ====================
	a_serr_route: assert property (@(posedge pclk) disable iff (!presetn)
		serr_in |=> interrupts[IRQ_SERR]) else $error("serr not routed");
	a_unused_low: assert property (@(posedge pclk) disable iff (!presetn)
		interrupts[199:0] == '0) else $error("unexpected low irq");
	a_event_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && claim && pwrite && paddr[11:0] == OFF_EVENT) |=> ##1 sev_out) else $error("no event");
	a_fwd_unchanged: assert property (@(posedge pclk) disable iff (!presetn)
		(fwd_state == FWD_IDLE && setup && !claim) |=> fwd_psel && fwd_paddr == $past(paddr)
		&& fwd_pwrite == $past(pwrite)) else $error("forward altered");
	a_msi_xlat_id: assert property (@(posedge pclk) disable iff (!presetn)
		(msi_state == MSI_IDLE && xlat_msi_req) |=> dma_pwdata == $past(xlat_id)
		&& dma_paddr == $past(ts_base)) else $error("translator msi wrong");
	a_dma_bounded: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(dma_psel) |-> ##1 dma_penable) else $error("dma no access phase");
	a_local_ready: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && claim) |=> pready) else $error("local no ready");
	a_ep_msi_rewrite: assert property (@(posedge pclk) disable iff (!presetn)
		(msi_state == MSI_IDLE && !xlat_msi_req && ep_msi_req == 2'b01 && ep_msi_addr == ts_base)
		|=> dma_pwdata == {16'h0000, $past(cfg_bus[0].bus_num), $past(cfg_bus[0].dev_num), 3'b000})
		else $error("payload not rewritten");
	c_forward: cover property (@(posedge pclk) disable iff (!presetn) fwd_state == FWD_DONE);
	c_msi: cover property (@(posedge pclk) disable iff (!presetn) msi_state == MSI_DONE);
	c_event: cover property (@(posedge pclk) disable iff (!presetn) sev_out);
endmodule
`default_nettype wire

// ### pcie_far_model.sv
/*
 * far side of the subsystem: downstream apb slave for forwarded transfers
 * and the dma write target. assumes the subsystem's pclk and presetn.
 */
`timescale 1ns/1ns
`default_nettype none
module pcie_far_model
	import pcie_subsys_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              slow,        // stretch every answer
	input  wire logic              fwd_psel,
	input  wire logic              fwd_penable,
	input  wire logic [ADDR_W-1:0] fwd_paddr,
	output logic      [DATA_W-1:0] fwd_prdata,
	output logic                   fwd_pready,
	output logic                   fwd_pslverr,
	input  wire logic              dma_psel,
	input  wire logic              dma_penable,
	output logic                   dma_pready
);
	// ==================== answer timing ====================
	logic [2:0] fwait;  // cycles spent in forwarded access
	logic [2:0] dwait;  // cycles spent in dma access
	logic       fgo;    // forwarded answer due now
	logic       dgo;    // dma answer due now
	assign fgo = fwd_psel && fwd_penable && !fwd_pready && fwait >= (slow ? 3'd3 : 3'd0);
	assign dgo = dma_psel && dma_penable && !dma_pready && dwait >= (slow ? 3'd3 : 3'd0);
	// completes forwarded and dma transfers
	// read data is the address inverted; released data flips each cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwait <= 3'd0;
			dwait <= 3'd0;
			fwd_pready <= 1'b0;
			dma_pready <= 1'b0;
			fwd_prdata <= '0;
			fwd_pslverr <= 1'b0;
		end else begin
			// faults every word with address bit 2 set, so error passing is seen
			fwd_pslverr <= fgo & fwd_paddr[2];
			fwd_pready <= fgo;
			dma_pready <= dgo;
			fwait <= (fwd_psel && fwd_penable && !fwd_pready) ? fwait + 3'd1 : 3'd0;
			dwait <= (dma_psel && dma_penable && !dma_pready) ? dwait + 3'd1 : 3'd0;
			fwd_prdata <= fgo ? ~fwd_paddr : ~fwd_prdata;
		end
	end
endmodule
`default_nettype wire

// ### pcie_host_subsystem_irq_msi_test.sv
/*
 * self-checking bench: apb master, msi stimulus and result queues.
 * assumes pcie_far_model answers the forwarding and dma ports.
 */
`timescale 1ns/1ns
`default_nettype none
module pcie_host_subsystem_irq_msi_test
	import pcie_subsys_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, sev_out, msi_busy;
	logic fwd_psel, fwd_penable, fwd_pwrite, fwd_pready, fwd_pslverr, xlat_msi_req, serr_in;
	logic dma_psel, dma_penable, dma_pwrite, dma_pready;
	logic [31:0] paddr, pwdata, prdata, fwd_paddr, fwd_pwdata, fwd_prdata, ep_msi_data, dma_pwdata, r, cfg;
	logic [1:0] ep_msi_req, cfg_hit;
	logic [7:0] cfg_bus_in, bus;
	logic [4:0] dev;
	logic [63:0] ep_msi_addr, dma_paddr, tsb;
	logic [223:0] interrupts;
	logic [33:0] exp_q[$], ae;  // {is_read, err, data}
	logic [96:0] dma_q[$], de;  // {data_only, addr, data}
	int seed, n_fail, total_checks, n;
	pcie_host_subsystem u_pcie_host_subsystem (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .fwd_psel, .fwd_penable, .fwd_pwrite, .fwd_paddr,
		.fwd_pwdata, .fwd_prdata, .fwd_pready, .fwd_pslverr, .ep_msi_req, .ep_msi_addr, .ep_msi_data,
		.xlat_msi_req, .serr_in, .cfg_bus_in, .cfg_hit, .dma_psel, .dma_penable, .dma_pwrite,
		.dma_paddr, .dma_pwdata, .dma_pready, .msi_busy, .interrupts, .sev_out);
	pcie_far_model u_pcie_far_model (.pclk, .presetn, .slow, .fwd_psel, .fwd_penable, .fwd_paddr,
		.fwd_prdata, .fwd_pready, .fwd_pslverr, .dma_psel, .dma_penable, .dma_pready);
	// ==================== helpers ====================
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task chk(input logic [96:0] g, input logic [96:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
		end
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one apb transfer; an idle edge first keeps drives apart
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] x, input logic er);
		@(posedge pclk);
		exp_q.push_back({~w, er, x});
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// msi request held until the dma cycle starts, then dropped
	task msi(input logic [1:0] q, input logic x, input logic [63:0] a, input logic [31:0] d, input logic [96:0] e);
		dma_q.push_back(e);
		ep_msi_req <= q; xlat_msi_req <= x; ep_msi_addr <= a; ep_msi_data <= d; slow <= ~slow;
		@(posedge pclk);
		while (dma_psel !== 1'b1) @(posedge pclk);
		ep_msi_req <= 2'b00; xlat_msi_req <= 1'b0;
		@(posedge pclk);
		while (msi_busy !== 1'b0) @(posedge pclk);
	endtask
	task defaults;
		apb(0, OFF_EP0_CFG, 0, EP_CFG_RST, 0);
		apb(0, OFF_EP1_CFG, 0, EP_CFG_RST, 0);
		apb(0, OFF_TS_BASE_LO, 0, TS_BASE_RST[31:0], 0);
		apb(0, OFF_TS_BASE_HI, 0, TS_BASE_RST[63:32], 0);
		apb(0, OFF_XLAT_ID, 0, XLAT_ID_RST, 0);
	endtask
	// ==================== result watchers ====================
	always @(posedge pclk) if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
		ae = exp_q.pop_front();
		chk(pslverr, ae[32]);
		if (ae[33]) chk(prdata, ae[31:0]);
	end
	always @(posedge pclk) if (dma_psel && dma_penable && dma_pready === 1'b1 && dma_q.size() > 0) begin
		de = dma_q.pop_front();
		if (de[96]) chk(dma_pwdata, de[31:0]);
		else chk({dma_paddr, dma_pwdata}, de[95:0]);
		chk({dma_pwrite, msi_busy}, 2'b11);
	end
	always @(posedge pclk) if (fwd_psel && fwd_penable && fwd_pready === 1'b1)
		chk({fwd_pwrite, fwd_paddr, fwd_pwdata}, {pwrite, paddr, pwdata});
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		end_of_test;
	end
	// ==================== main sequence ====================
	initial begin
		seed = 32'h074350fc;
		{psel, penable, pwrite, paddr, pwdata, ep_msi_req, ep_msi_addr, ep_msi_data} = '0;
		{xlat_msi_req, serr_in, cfg_bus_in, slow, n_fail, total_checks} = '0;
		presetn = 1'b0;  // bench drives reset
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		defaults();
		r = $random(seed);
		bus = r[7:0];
		dev = r[12:8];
		cfg = {9'h0, 3'b001, 4'hF, 3'h0, dev, bus};
		apb(1, OFF_EP0_CFG, cfg, 0, 0);
		apb(0, OFF_EP0_CFG, 0, cfg, 0);
		apb(0, OFF_EP0_CAP, 0, {16'h0, INT_PIN_INTA, 1'b0, dev[1:0] + PIN_IDX_INTA, 2'b10, 3'b001}, 0);
		apb(0, OFF_EP1_CAP, 0, {16'h0, INT_PIN_INTA, 8'h0}, 0);
		apb(0, 32'h0000_0FFC, 0, BUS_ERR_DATA, 1);
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			r = $random(seed);
			apb(i[1], r | 32'h0000_1000, r, ~(r | 32'h0000_1000), r[2]);
		end
		cfg_bus_in <= bus;
		repeat (3) @(posedge pclk);
		chk(cfg_hit, {bus == 8'h00, 1'b1});
		apb(1, OFF_INTX, 32'h0000_0001, 0, 0);
		serr_in <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(interrupts[203:200], 4'b0001 << dev[1:0]);
		chk(interrupts[207], 1'b1);
		chk(|{interrupts[223:208], interrupts[206:204], interrupts[199:0]}, 1'b0);
		apb(0, OFF_STATUS, 0, {27'h0, 3'b001, bus == 8'h00, 1'b1}, 0);
		serr_in <= 1'b0;
		apb(1, OFF_EVENT, 32'h0000_0001, 0, 0);
		n = 0;
		repeat (6) begin
			@(posedge pclk);
			if (sev_out === 1'b1) n++;
		end
		chk(n, 1);
		r = $random(seed);
		tsb = {r, r & 32'hFFFF_FFFC};
		apb(1, OFF_TS_BASE_LO, tsb[31:0], 0, 0);
		apb(1, OFF_TS_BASE_HI, tsb[63:32], 0, 0);
		apb(0, OFF_TS_BASE_HI, 0, tsb[63:32], 0);
		@(posedge pclk);
		msi(2'b01, 0, tsb, r, {1'b0, tsb, 16'h0, bus, dev, 3'b000});
		msi(2'b01, 0, tsb + 64'h40, r, {1'b0, tsb + 64'h40, r});
		msi(2'b10, 0, tsb, r, {1'b0, tsb, 32'h0});
		msi(2'b00, 1, 64'h0, r, {1'b1, 64'h0, XLAT_ID_RST});
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		defaults();
		end_of_test;
	end
endmodule
`default_nettype wire
